// ### sdb_partner.sv
// Far-side model of the serial data buffer: a slave that answers the
// block's master pins and a master task that drives its slave pins.
// Assumes CPOL 0, CPHA 1, and a 32 ns link clock made only within frames.
`timescale 1ns/1ns
module sdb_partner (
  // Block acting as master
  input wire logic sck_in,
  input wire logic ss_n_in,
  input wire logic mosi_in,
  input wire logic wide_in,
  output logic miso_out,
  // Block acting as slave
  input wire logic miso_in,
  output logic sck_out,
  output logic mosi_out,
  output logic ss_n_out
);
  logic [15:0] s_tx = 16'h0000;
  logic [15:0] s_rx = 16'h0000;
  logic [15:0] sh = 16'h0000;
  int rises = 0;
  int frames = 0;
  time t_fall = 0;
  time t_rise = 0;
  time lead = 0;
  time gap = 0;

  ////////////////////////////////////////////////////////////////////////
  // Idle levels; the link clock stands still outside frames
  initial begin
    miso_out = 1'b0;
    sck_out = 1'b0;
    mosi_out = 1'b0;
    ss_n_out = 1'b1;
  end

  // Selection: load reply, measure the idle gap before it
  always @(negedge ss_n_in) begin
    sh = wide_in ? s_tx : {s_tx[7:0], 8'h00};
    s_rx = 16'h0000;
    rises = 0;
    gap = $time - t_rise;
    t_fall = $time;
  end

  // Release: no pull-up, so show the inverse of the last level
  always @(posedge ss_n_in) begin
    miso_out = ~miso_out;
    t_rise = $time;
    frames++;
    s_tx = s_tx + 16'h1111; // Fresh reply each frame
  end

  // First edge of a bit: slave drives its bit
  always @(posedge sck_in) begin
    if (!ss_n_in) begin
      if (rises == 0) lead = $time - t_fall;
      rises++;
      miso_out = sh[15];
      sh = sh << 1;
    end
  end

  // Second edge: latch the incoming bit. SCK rests low outside frames,
  // and the last fall shares a time step with the SS release
  always @(negedge sck_in) begin
    s_rx = {s_rx[14:0], mosi_in};
  end

  ////////////////////////////////////////////////////////////////////////
  // Narrow frame into the block's slave pins, half period 16 ns
  task automatic frame(input logic [7:0] w, input bit hold,
                       output logic [7:0] got);
    int i;
    ss_n_out = 1'b0;
    #16;
    for (i = 7; i >= 0; i--) begin
      sck_out = 1'b1;
      mosi_out = w[i];
      #16;
      sck_out = 1'b0;
      got = {got[6:0], miso_in};
      #16;
    end
    if (!hold) begin
      ss_n_out = 1'b1;
      mosi_out = ~mosi_out;
    end
  endtask
endmodule // sdb_partner

// ### sdb_pkg.sv
// Shared constants, types and decode for the serial data buffer block.
// Assumes an 8-bit register port and a 25 MHz system clock.
package sdb_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Register offsets and status bit positions
  localparam logic [1:0] OFS_DATA_HI = 2'h0;
  localparam logic [1:0] OFS_DATA_LO = 2'h1;
  localparam logic [1:0] OFS_STATUS = 2'h2;
  localparam logic [1:0] OFS_CTRL = 2'h3;
  localparam int ST_RXF_BIT = 7;
  localparam int ST_TXE_BIT = 5;
  localparam int ST_BUSY_BIT = 0;

  ////////////////////////////////////////////////////////////////////////
  // Reset values and the narrow-word mask
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [15:0] LOW_MASK = 16'h00ff;

  ////////////////////////////////////////////////////////////////////////
  // Timing: half an SCK period, also the least SS idle time
  localparam int SYS_CLK_NS = 40;
  localparam int SCK_HALF_NS = 500;
  localparam int HALF_CYC = (SCK_HALF_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
  localparam logic [3:0] HALF_LAST = 4'(HALF_CYC - 1);

  ////////////////////////////////////////////////////////////////////////
  // Bit index of the last bit per transfer width
  localparam logic [3:0] LAST_NARROW = 4'h7;
  localparam logic [3:0] LAST_WIDE = 4'hf;

  ////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_LEAD = 3'b001,
    ST_HI = 3'b010,
    ST_LO = 3'b011,
    ST_GAP = 3'b100
  } sdb_mst_e;

  // Control byte, low nibble
  typedef struct packed {
    logic wide;
    logic ssoe;
    logic master;
    logic en;
  } sdb_ctrl_s;

  // Register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [1:0] addr;
    logic [7:0] wdata;
  } sdb_bus_s;

  // Last bit index for the selected width
  function automatic logic [3:0] last_bit(input logic wide);
    last_bit = wide ? LAST_WIDE : LAST_NARROW;
  endfunction

  // Word as placed in the shifter, narrow words in the top byte
  function automatic logic [15:0] tx_align(input logic wide,
                                           input logic [15:0] w);
    tx_align = wide ? w : {w[7:0], 8'h00};
  endfunction

endpackage

// ### sdb_top.sv
// Data buffering and transfer sequencing of a serial peripheral port.
// Assumes an 8-bit register port on SYS_CLK_IN and a slave-side SCK that
// stands still outside frames; CPOL is 0 and CPHA is 1 throughout.
//
// Contract
// - Data word is a high byte plus low byte forming 16 bits.
// - Writing the data register queues it; reads give received data.
// - Master starts queued data right after the previous transfer ends.
// - Transmit-empty flag is cleared whenever the data register takes data.
// - Word received with flag clear goes to data register, sets flag.
// - Word received with flag set is held; data register unchanged.
// - Servicing before a third transfer copies held word, flag kept.
// - Servicing after a third transfer starts drops the held word.
// - Slave with SS held low sends the last received word.
// - Slave sends data register only after SS high half an SCK period; the code takes any SS high seen at ssn_s2.
// - Master with SS output toggles SS high for idle time between words.
// - First SCK edge comes half a period after start; slave drives bit.
// - Second edge half a period later; both sides sample there.
// - SCK cycles per transfer are 8, or 16 with wide select.
//
// The implementer's own choices: the address map and the plain strobed port.
`timescale 1ns/1ns
module sdb_top (
  // System clock and reset
  input wire logic SYS_CLK_IN,
  input wire logic RESET_N_IN,
  // Register port
  input wire logic [1:0] REG_ADDR_IN,
  input wire logic [7:0] REG_WDATA_IN,
  input wire logic REG_WR_IN,
  input wire logic REG_RD_IN,
  output logic [7:0] REG_RDATA_OUT,
  // Master side pins
  output logic SCK_OUT,
  output logic SCK_OE_OUT,
  output logic MOSI_OUT,
  output logic MOSI_OE_OUT,
  input wire logic MISO_IN,
  output logic SS_N_OUT,
  output logic SS_N_OE_OUT,
  // Slave side pins, SCK_IN is the link clock
  input wire logic SCK_IN,
  input wire logic MOSI_IN,
  input wire logic SS_N_IN,
  output logic MISO_OUT,
  output logic MISO_OE_OUT
);

  ////////////////////////////////////////////////////////////////////////
  // System domain state
  sdb_pkg::sdb_bus_s bus;
  sdb_pkg::sdb_ctrl_s ctrl, next_ctrl;
  sdb_pkg::sdb_mst_e st, next_st;
  logic [7:0] tx_hi, next_tx_hi;
  logic [15:0] tx_word, next_tx_word;
  logic tx_pend, next_tx_pend;
  logic [15:0] rx_data, next_rx_data;
  logic rxf, next_rxf;
  logic [15:0] held, next_held;
  logic held_v, next_held_v;
  logic [15:0] last_rx, next_last_rx;
  logic gap, next_gap;
  logic [15:0] slv_tx, next_slv_tx;
  logic [7:0] rdata, next_rdata;
  logic [3:0] tmr, next_tmr;
  logic [3:0] bitcnt, next_bitcnt;
  logic [15:0] sh_tx, next_sh_tx;
  logic [15:0] sh_rx, next_sh_rx;
  logic sck, next_sck;
  logic mosi, next_mosi;
  logic ss_n, next_ss_n;
  logic sck_oe, next_sck_oe;
  logic ss_oe, next_ss_oe;
  logic miso_oe, next_miso_oe;
  // Synchronisers
  logic miso_s1, miso_s2;
  logic ssn_s1, ssn_s2;
  logic dtg_s1, dtg_s2, dtg_s3;
  logic stg_s1, stg_s2, stg_s3;
  // Events and helpers
  logic tend, m_start, m_done, s_start, s_done;
  logic start_ev, done_ev, service;
  logic [15:0] m_word, raw_word, word;
  logic [7:0] status;

  ////////////////////////////////////////////////////////////////////////
  // Link domain state
  logic lnk_rst, core_rst;
  logic [3:0] cntp, next_cntp;
  logic [15:0] l_shtx, next_l_shtx;
  logic l_miso, next_l_miso;
  logic l_stgl, next_l_stgl;
  logic [3:0] cntn, next_cntn;
  logic [15:0] l_shrx, next_l_shrx;
  logic [15:0] l_rxw, next_l_rxw;
  logic l_dtgl, next_l_dtgl;
  logic [15:0] l_word;

  assign bus = '{wr: REG_WR_IN, rd: REG_RD_IN, addr: REG_ADDR_IN,
                 wdata: REG_WDATA_IN};

  ////////////////////////////////////////////////////////////////////////
  // Pin and event synchronisers; pins are read at stage two, events at stages two and three
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RESET_N_IN) begin
      miso_s1 <= 1'b0;
      miso_s2 <= 1'b0;
      ssn_s1 <= 1'b1;
      ssn_s2 <= 1'b1;
      {dtg_s1, dtg_s2, dtg_s3} <= 3'h0;
      {stg_s1, stg_s2, stg_s3} <= 3'h0;
    end else begin
      miso_s1 <= MISO_IN;
      miso_s2 <= miso_s1;
      ssn_s1 <= SS_N_IN;
      ssn_s2 <= ssn_s1;
      {dtg_s1, dtg_s2, dtg_s3} <= {l_dtgl, dtg_s1, dtg_s2};
      {stg_s1, stg_s2, stg_s3} <= {l_stgl, stg_s1, stg_s2};
    end
  end

  // Slave events count only while enabled as slave
  assign s_done = (dtg_s2 ^ dtg_s3) & ctrl.en & ~ctrl.master;
  assign s_start = (stg_s2 ^ stg_s3) & ctrl.en & ~ctrl.master;
  assign tend = (tmr == sdb_pkg::HALF_LAST);
  assign m_word = {sh_rx[14:0], miso_s2};
  assign m_done = (st == sdb_pkg::ST_HI) && tend &&
                  (bitcnt == sdb_pkg::last_bit(ctrl.wide));
  assign m_start = (st == sdb_pkg::ST_IDLE) && ctrl.en && ctrl.master &&
                   tx_pend;
  assign start_ev = m_start | s_start;
  assign done_ev = m_done | s_done;
  assign raw_word = m_done ? m_word : l_rxw;
  // Narrow transfers never carry a high byte
  assign word = ctrl.wide ? raw_word :
                (raw_word & sdb_pkg::LOW_MASK);
  assign service = bus.rd && (bus.addr == sdb_pkg::OFS_DATA_LO) && rxf;

  // Status byte, other bits read as zero
  always_comb begin
    status = 8'h00;
    status[sdb_pkg::ST_RXF_BIT] = rxf;
    status[sdb_pkg::ST_TXE_BIT] = ~tx_pend;
    status[sdb_pkg::ST_BUSY_BIT] = (st != sdb_pkg::ST_IDLE);
  end

  ////////////////////////////////////////////////////////////////////////
  // System domain next state: registers, receive buffer, master sequencer
  always_comb begin
    next_ctrl = ctrl;
    next_tx_hi = tx_hi;
    next_tx_word = tx_word;
    next_tx_pend = tx_pend;
    next_rx_data = rx_data;
    next_rxf = rxf;
    next_held = held;
    next_held_v = held_v;
    next_last_rx = last_rx;
    next_gap = gap;
    next_st = st;
    next_tmr = tend ? 4'h0 : 4'(tmr + 4'h1);
    next_bitcnt = bitcnt;
    next_sh_tx = sh_tx;
    next_sh_rx = sh_rx;
    next_sck = sck;
    next_mosi = mosi;
    next_ss_n = ss_n;
    // Read data stand one cycle only, zero otherwise
    next_rdata = 8'h00;
    if (bus.rd) begin
      case (bus.addr)
        sdb_pkg::OFS_DATA_HI: next_rdata = rx_data[15:8];
        sdb_pkg::OFS_DATA_LO: next_rdata = rx_data[7:0];
        sdb_pkg::OFS_STATUS: next_rdata = status;
        default: next_rdata = {4'h0, ctrl};
      endcase
    end
    // Master sequencer, half-period steps
    case (st)
      sdb_pkg::ST_IDLE: begin
        next_tmr = 4'h0;
        if (m_start) begin
          next_sh_tx = sdb_pkg::tx_align(ctrl.wide, tx_word);
          next_tx_pend = 1'b0;
          next_bitcnt = 4'h0;
          next_ss_n = ~ctrl.ssoe;
          next_st = sdb_pkg::ST_LEAD;
        end
      end
      sdb_pkg::ST_LEAD, sdb_pkg::ST_LO: begin
        if (tend) begin
          // Launch edge after the half-period delay
          next_sck = 1'b1;
          next_mosi = sh_tx[15];
          next_sh_tx = {sh_tx[14:0], 1'b0};
          next_st = sdb_pkg::ST_HI;
        end
      end
      sdb_pkg::ST_HI: begin
        if (tend) begin
          // Latch edge, MISO through the synchroniser
          next_sck = 1'b0;
          next_sh_rx = m_word;
          next_bitcnt = 4'(bitcnt + 4'h1);
          if (m_done) begin
            next_ss_n = 1'b1;
            next_st = sdb_pkg::ST_GAP;
          end else begin
            next_st = sdb_pkg::ST_LO;
          end
        end
      end
      sdb_pkg::ST_GAP: begin
        // SS held high for the idle time before any next word
        if (tend) begin
          next_st = sdb_pkg::ST_IDLE;
        end
      end
      default: begin
        next_st = sdb_pkg::ST_IDLE;
        next_sck = 1'b0;
        next_ss_n = 1'b1;
      end
    endcase
    // Slave: a gap in SS selects the data register for the next word
    if (ssn_s2) begin
      next_gap = 1'b1;
    end
    if (s_start) begin
      next_gap = 1'b0;
      if (gap) begin
        next_tx_pend = 1'b0;
      end
    end
    // A new transfer makes any held word stale
    if (start_ev) begin
      next_held_v = 1'b0;
    end
    if (service) begin
      if (held_v && !start_ev) begin
        next_rx_data = held;
        next_held_v = 1'b0;
      end else begin
        next_rxf = 1'b0;
      end
    end
    // Completion after service, so a set beats a clear
    if (done_ev) begin
      next_last_rx = word;
      if (!next_rxf) begin
        next_rx_data = word;
        next_rxf = 1'b1;
      end else begin
        next_held = word;
        next_held_v = 1'b1;
      end
    end
    // Writes last, so a write beats a load in the same cycle
    if (bus.wr) begin
      case (bus.addr)
        sdb_pkg::OFS_DATA_HI: next_tx_hi = bus.wdata;
        sdb_pkg::OFS_DATA_LO: begin
          next_tx_word = {tx_hi, bus.wdata};
          next_tx_pend = 1'b1;
        end
        sdb_pkg::OFS_CTRL: next_ctrl = sdb_pkg::sdb_ctrl_s'(bus.wdata[3:0]);
        default: next_ctrl = ctrl;
      endcase
    end
  end

  // Slave word and pin enables, all registered
  always_comb begin
    next_slv_tx = gap ? tx_word : last_rx;
    next_sck_oe = ctrl.en & ctrl.master;
    next_ss_oe = ctrl.en & ctrl.master & ctrl.ssoe;
    next_miso_oe = ctrl.en & ~ctrl.master & ~ssn_s2;
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (!RESET_N_IN) begin
      ctrl <= sdb_pkg::sdb_ctrl_s'(4'h0);
      st <= sdb_pkg::ST_IDLE;
      tx_hi <= sdb_pkg::RST_BYTE;
      tx_word <= sdb_pkg::RST_WORD;
      tx_pend <= 1'b0;
      rx_data <= sdb_pkg::RST_WORD;
      rxf <= 1'b0;
      held <= sdb_pkg::RST_WORD;
      held_v <= 1'b0;
      last_rx <= sdb_pkg::RST_WORD;
      gap <= 1'b1;
      slv_tx <= sdb_pkg::RST_WORD;
      rdata <= sdb_pkg::RST_BYTE;
      tmr <= 4'h0;
      bitcnt <= 4'h0;
      sh_tx <= sdb_pkg::RST_WORD;
      sh_rx <= sdb_pkg::RST_WORD;
      sck <= 1'b0;
      mosi <= 1'b0;
      ss_n <= 1'b1;
      sck_oe <= 1'b0;
      ss_oe <= 1'b0;
      miso_oe <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      st <= next_st;
      tx_hi <= next_tx_hi;
      tx_word <= next_tx_word;
      tx_pend <= next_tx_pend;
      rx_data <= next_rx_data;
      rxf <= next_rxf;
      held <= next_held;
      held_v <= next_held_v;
      last_rx <= next_last_rx;
      gap <= next_gap;
      slv_tx <= next_slv_tx;
      rdata <= next_rdata;
      tmr <= next_tmr;
      bitcnt <= next_bitcnt;
      sh_tx <= next_sh_tx;
      sh_rx <= next_sh_rx;
      sck <= next_sck;
      mosi <= next_mosi;
      ss_n <= next_ss_n;
      sck_oe <= next_sck_oe;
      ss_oe <= next_ss_oe;
      miso_oe <= next_miso_oe;
    end
  end

  assign REG_RDATA_OUT = rdata;
  assign SCK_OUT = sck;
  assign SCK_OE_OUT = sck_oe;
  assign MOSI_OUT = mosi;
  assign MOSI_OE_OUT = sck_oe;
  assign SS_N_OUT = ss_n;
  assign SS_N_OE_OUT = ss_oe;
  assign MISO_OE_OUT = miso_oe;
  assign MISO_OUT = l_miso;

  ////////////////////////////////////////////////////////////////////////
  // Link domain: SCK stands still between frames, so resets act at once.
  // Counters restart whenever SS is high; toggles and the received word
  // survive SS so the system side can still collect them.
  assign lnk_rst = SS_N_IN | ~RESET_N_IN;
  assign core_rst = ~RESET_N_IN;

  // Launch edge: load at bit 0, slv_tx is quiet at frame start
  always_comb begin
    next_cntp = (cntp == sdb_pkg::last_bit(ctrl.wide)) ? 4'h0 :
                4'(cntp + 4'h1);
    next_l_stgl = l_stgl;
    if (cntp == 4'h0) begin
      next_l_shtx = sdb_pkg::tx_align(ctrl.wide, slv_tx);
      next_l_stgl = ~l_stgl;
    end else begin
      next_l_shtx = l_shtx;
    end
    next_l_miso = next_l_shtx[15];
    next_l_shtx = {next_l_shtx[14:0], 1'b0};
  end

  always_ff @(posedge SCK_IN or posedge lnk_rst) begin
    if (lnk_rst) begin
      cntp <= 4'h0;
      l_shtx <= sdb_pkg::RST_WORD;
    end else begin
      cntp <= next_cntp;
      l_shtx <= next_l_shtx;
    end
  end

  always_ff @(posedge SCK_IN or posedge core_rst) begin
    if (core_rst) begin
      l_miso <= 1'b0;
      l_stgl <= 1'b0;
    end else begin
      l_miso <= next_l_miso;
      l_stgl <= next_l_stgl;
    end
  end

  // Latch edge: MOSI is synchronous to SCK here
  assign l_word = {l_shrx[14:0], MOSI_IN};
  always_comb begin
    next_l_shrx = l_word;
    next_l_rxw = l_rxw;
    next_l_dtgl = l_dtgl;
    next_cntn = 4'(cntn + 4'h1);
    if (cntn == sdb_pkg::last_bit(ctrl.wide)) begin
      next_cntn = 4'h0;
      next_l_rxw = l_word;
      next_l_dtgl = ~l_dtgl;
    end
  end

  always_ff @(negedge SCK_IN or posedge lnk_rst) begin
    if (lnk_rst) begin
      cntn <= 4'h0;
      l_shrx <= sdb_pkg::RST_WORD;
    end else begin
      cntn <= next_cntn;
      l_shrx <= next_l_shrx;
    end
  end

  always_ff @(negedge SCK_IN or posedge core_rst) begin
    if (core_rst) begin
      l_rxw <= sdb_pkg::RST_WORD;
      l_dtgl <= 1'b0;
    end else begin
      l_rxw <= next_l_rxw;
      l_dtgl <= next_l_dtgl;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks on the system domain
  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (!RESET_N_IN);

  sequence lead_wait;
    (st == sdb_pkg::ST_LEAD) && tend;
  endsequence
  sequence first_edge;
    SCK_OUT && (st == sdb_pkg::ST_HI) && (bitcnt == 4'h0);
  endsequence

  txe_clear_a: assert property (
    bus.wr && bus.addr == sdb_pkg::OFS_DATA_LO |=> !status[5])
    else $error("transmit empty not cleared by write");
  rxf_load_a: assert property (
    done_ev && !rxf && !service |=> rxf && rx_data == $past(word))
    else $error("received word not moved to data register");
  rx_hold_a: assert property (
    done_ev && rxf && !service |=> rx_data == $past(rx_data) && held_v)
    else $error("data register changed while full");
  held_copy_a: assert property (
    service && held_v && !start_ev |=> rxf && rx_data == $past(held))
    else $error("held word not copied on service");
  held_drop_a: assert property (
    start_ev && !done_ev |=> !held_v)
    else $error("held word survived a new transfer");
  auto_start_a: assert property (
    m_start |=> st == sdb_pkg::ST_LEAD && !tx_pend ##13 first_edge)
    else $error("queued word not started");
  first_edge_a: assert property (
    lead_wait |=> first_edge)
    else $error("first SCK edge misplaced");
  latch_edge_a: assert property (
    $rose(SCK_OUT) |-> SCK_OUT [*8] ##1 SCK_OUT [*5] ##1 !SCK_OUT)
    else $error("SCK high phase not half a period");
  ss_idle_a: assert property (
    $rose(st == sdb_pkg::ST_GAP) |-> SS_N_OUT [*8] ##1 SS_N_OUT [*5])
    else $error("SS idle time too short");
  width_a: assert property (
    $rose(SS_N_OUT) |-> bitcnt == (ctrl.wide ? 4'h0 : 4'h8))
    else $error("wrong bit count per transfer");
  narrow_a: assert property (
    done_ev && !ctrl.wide && !rxf |=> rx_data[15:8] == 8'h00)
    else $error("high byte used in narrow transfer");
  slv_word_a: assert property (
    !gap |=> slv_tx == $past(last_rx))
    else $error("slave word not last received");
  slv_gap_a: assert property (
    ssn_s2 ##1 !s_start |=> slv_tx == $past(tx_word))
    else $error("slave gap did not select data register");

endmodule // sdb_top

// ### sdb_top_test.sv
// Self-checking bench for the serial data buffer block.
// Assumes sdb_pkg, sdb_top and sdb_partner are compiled before it.
`timescale 1ns/1ns
module sdb_top_test;
  logic sys_clk;
  logic reset_n;
  logic [1:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic wide;
  wire [7:0] rdata;
  wire sck_m, sck_oe, mosi_m, mosi_oe, ss_m, ss_oe;
  wire miso_s, miso_oe, miso_m, sck_s, mosi_s, ss_s;
  wire sck_w;
  wire ss_w;
  int bad_count = 0;
  int tests_run = 0;

  // Undriven master SCK and SS rest at their idle levels
  assign sck_w = sck_oe ? sck_m : 1'b0;
  assign ss_w = ss_oe ? ss_m : 1'b1;

  sdb_top i_sdb_top (.SYS_CLK_IN(sys_clk), .RESET_N_IN(reset_n),
    .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata), .REG_WR_IN(wr),
    .REG_RD_IN(rd), .REG_RDATA_OUT(rdata), .SCK_OUT(sck_m),
    .SCK_OE_OUT(sck_oe), .MOSI_OUT(mosi_m), .MOSI_OE_OUT(mosi_oe),
    .MISO_IN(miso_m), .SS_N_OUT(ss_m), .SS_N_OE_OUT(ss_oe),
    .SCK_IN(sck_s), .MOSI_IN(mosi_s), .SS_N_IN(ss_s),
    .MISO_OUT(miso_s), .MISO_OE_OUT(miso_oe));

  sdb_partner i_sdb_partner (.sck_in(sck_w), .ss_n_in(ss_w),
    .mosi_in(mosi_m), .wide_in(wide), .miso_out(miso_m),
    .miso_in(miso_s), .sck_out(sck_s), .mosi_out(mosi_s),
    .ss_n_out(ss_s));

  ////////////////////////////////////////////////////////////////////////
  // Clock and reset
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  task close_out;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task check(input string name, input logic [15:0] exp,
             input logic [15:0] got);
    tests_run++;
    if (exp !== got) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", name, exp, got);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Register port: one-cycle strobes, read data in the next cycle only
  task wr_reg(input logic [1:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask

  task rd_reg(input logic [1:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  task chk_reg(input string name, input logic [1:0] a,
               input logic [7:0] exp);
    logic [7:0] d;
    rd_reg(a, d);
    check(name, {8'h00, exp}, {8'h00, d});
  endtask

  task chk_st(input string name, input int b, input logic exp);
    logic [7:0] d;
    rd_reg(sdb_pkg::OFS_STATUS, d);
    check(name, {15'h0000, exp}, {15'h0000, d[b]});
  endtask

  // Bounded waits; running out ends the run as a mismatch
  task wait_rxf;
    logic [7:0] d;
    int k;
    d = 8'h00;
    for (k = 0; k < 2000 && d[sdb_pkg::ST_RXF_BIT] !== 1'b1; k++)
      rd_reg(sdb_pkg::OFS_STATUS, d);
    if (d[sdb_pkg::ST_RXF_BIT] !== 1'b1) begin
      bad_count++;
      $display("FAIL receive_full_flag expected 1 seen %b", d[7]);
      close_out();
    end
  endtask

  task wait_frames(input int n);
    int k;
    for (k = 0; k < 5000 && i_sdb_partner.frames < n; k++)
      @(posedge sys_clk);
    if (i_sdb_partner.frames < n) begin
      bad_count++;
      $display("FAIL frames expected %0d seen %0d", n,
               i_sdb_partner.frames);
      close_out();
    end
    repeat (20) @(posedge sys_clk);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Scenarios
  task t_reset;
    chk_reg("data_high_reset", sdb_pkg::OFS_DATA_HI, 8'h00);
    chk_reg("data_low_reset", sdb_pkg::OFS_DATA_LO, 8'h00);
    chk_reg("status_reset", sdb_pkg::OFS_STATUS, 8'h20);
    chk_reg("control_reset", sdb_pkg::OFS_CTRL, 8'h00);
  endtask

  task t_master_narrow;
    int base;
    base = i_sdb_partner.frames;
    wide <= 1'b0;
    i_sdb_partner.s_tx = 16'h003c;
    wr_reg(sdb_pkg::OFS_CTRL, 8'h07);
    wr_reg(sdb_pkg::OFS_DATA_HI, 8'hff);
    wr_reg(sdb_pkg::OFS_DATA_LO, 8'ha5);
    wait_frames(base + 1);
    wait_rxf();
    check("mosi_word", 16'h00a5, i_sdb_partner.s_rx);
    check("sck_count", 16'h0008, 16'(i_sdb_partner.rises));
    check("lead_ns", 16'(sdb_pkg::HALF_CYC * sdb_pkg::SYS_CLK_NS),
          16'(i_sdb_partner.lead));
    chk_reg("rx_high", sdb_pkg::OFS_DATA_HI, 8'h00);
    chk_reg("rx_low", sdb_pkg::OFS_DATA_LO, 8'h3c);
    chk_st("tx_empty", sdb_pkg::ST_TXE_BIT, 1'b1);
  endtask

  task t_master_burst;
    int base;
    base = i_sdb_partner.frames;
    wide <= 1'b1;
    i_sdb_partner.s_tx = 16'h1234;
    wr_reg(sdb_pkg::OFS_CTRL, 8'h0f);
    wr_reg(sdb_pkg::OFS_DATA_HI, 8'hab);
    wr_reg(sdb_pkg::OFS_DATA_LO, 8'hcd);
    wr_reg(sdb_pkg::OFS_DATA_HI, 8'h01);
    wr_reg(sdb_pkg::OFS_DATA_LO, 8'h02);
    wait_frames(base + 2);
    check("mosi_wide", 16'h0102, i_sdb_partner.s_rx);
    check("sck_wide", 16'h0010, 16'(i_sdb_partner.rises));
    check("ss_gap_ok", 16'h0001, 16'(i_sdb_partner.gap >=
          sdb_pkg::HALF_CYC * sdb_pkg::SYS_CLK_NS));
    chk_reg("first_high", sdb_pkg::OFS_DATA_HI, 8'h12);
    chk_reg("first_low", sdb_pkg::OFS_DATA_LO, 8'h34);
    chk_st("flag_kept", sdb_pkg::ST_RXF_BIT, 1'b1);
    chk_reg("held_high", sdb_pkg::OFS_DATA_HI, 8'h23);
    chk_reg("held_low", sdb_pkg::OFS_DATA_LO, 8'h45);
    chk_st("flag_clear", sdb_pkg::ST_RXF_BIT, 1'b0);
  endtask

  task t_master_drop;
    int base;
    base = i_sdb_partner.frames;
    i_sdb_partner.s_tx = 16'h3456;
    wr_reg(sdb_pkg::OFS_DATA_LO, 8'h0a);
    wr_reg(sdb_pkg::OFS_DATA_LO, 8'h0b);
    wait_frames(base + 2);
    wr_reg(sdb_pkg::OFS_DATA_LO, 8'h0c);
    repeat (30) @(posedge sys_clk);
    chk_reg("late_low", sdb_pkg::OFS_DATA_LO, 8'h56);
    chk_st("held_dropped", sdb_pkg::ST_RXF_BIT, 1'b0);
    wait_frames(base + 3);
    wait_rxf();
    chk_reg("third_high", sdb_pkg::OFS_DATA_HI, 8'h56);
    chk_reg("third_low", sdb_pkg::OFS_DATA_LO, 8'h78);
  endtask

  task t_slave;
    logic [7:0] got;
    wr_reg(sdb_pkg::OFS_CTRL, 8'h01);
    wr_reg(sdb_pkg::OFS_DATA_LO, 8'h5a);
    repeat (5) @(posedge sys_clk);
    #7 i_sdb_partner.frame(8'hc3, 1'b0, got);
    check("slave_sends_data", 16'h005a, {8'h00, got});
    wait_rxf();
    chk_reg("slave_rx", sdb_pkg::OFS_DATA_LO, 8'hc3);
    @(posedge sys_clk);
    #7 i_sdb_partner.frame(8'h66, 1'b1, got);
    repeat (10) @(posedge sys_clk);
    #3 check("miso_enable", 16'h0001, {15'h0000, miso_oe});
    i_sdb_partner.frame(8'h99, 1'b0, got);
    check("slave_echo", 16'h0066, {8'h00, got});
    wr_reg(sdb_pkg::OFS_DATA_LO, 8'h44);
    repeat (5) @(posedge sys_clk);
    #7 i_sdb_partner.frame(8'h11, 1'b0, got);
    check("slave_after_gap", 16'h0044, {8'h00, got});
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    reset_n = 1'b0;
    addr = 2'h0;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    wide = 1'b0;
    repeat (2) @(posedge sys_clk);
    reset_n <= 1'b1;
    t_reset();
    t_master_narrow();
    t_master_burst();
    t_master_drop();
    t_slave();
    close_out();
  end
endmodule // sdb_top_test
